// ==== hdl/ssp_clkgen.sv ====
// Bit-clock generator: input selection, divider and high and low phase widths.
`timescale 1ns/1ps
module ssp_clkgen
(
  input wire logic sys_clk,
  input wire logic rst,
  ssp_gen_if.gen   io
);

  // Whole state of the generator, including the counter the checks read.
  typedef struct packed
  {
    logic        pre;       // Halves the CPU clock to one tick per half input period.
    logic        ext_prev;  // Previous external level, for edge detection.
    logic [8:0]  cnt;       // Half input periods spent in the current phase.
    logic        level;     // Generated bit clock level.
    logic        rise;      // Registered rising-edge pulse.
    logic        fall;      // Registered falling-edge pulse.
    logic [11:0] cyc;       // System cycles since the last rising edge.
    logic        seen;      // A rising edge has occurred since the generator started.
  } ssp_gen_state_t;

  localparam ssp_gen_state_t GEN_RESET = '0;

  ssp_gen_state_t st_reg;
  ssp_gen_state_t st_next;
  logic           tick;

  //////////////////////////////////////////////////////////////////////////////////////////////

  // Counting half input periods lets a zero divider give a period of one input clock.
  always_comb
  begin
    st_next          = st_reg;
    tick             = 1'b0;
    st_next.rise     = 1'b0;
    st_next.fall     = 1'b0;
    st_next.ext_prev = io.ext_level;
    if (!io.run)
    begin
      // Parked with the prescaler primed: the first tick lands in the first running
      // cycle, so select leads the first edge by the full width and not one cycle more.
      st_next.pre   = 1'b1;
      st_next.cnt   = 9'h000;
      st_next.level = 1'b1;
      st_next.cyc   = 12'h000;
      st_next.seen  = 1'b0;
    end
    else
    begin
      if (io.input_select)
      begin
        // CPU input: a tick every two cycles is half of a four-cycle input period.
        st_next.pre = ~st_reg.pre;  // RQ2
        tick        = st_reg.pre;
      end
      else
      begin
        // External input: both edges of the pin each mark half an input period.
        tick = io.ext_level != st_reg.ext_prev;  // RQ2
      end
      if (tick)
      begin
        if (st_reg.level && st_reg.cnt + 9'h001 == ssp_pkg::hi_halves(io.divider))
        begin
          st_next.level = 1'b0;  // RQ4
          st_next.cnt   = 9'h000;
          st_next.fall  = 1'b1;
        end
        else if (!st_reg.level && st_reg.cnt + 9'h001 == ssp_pkg::lo_halves(io.divider))
        begin
          st_next.level = 1'b1;  // RQ3
          st_next.cnt   = 9'h000;
          st_next.rise  = 1'b1;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + 9'h001;
        end
      end
      st_next.cyc  = st_reg.rise ? 12'h001 : st_reg.cyc + 12'h001;
      st_next.seen = st_reg.seen | st_reg.rise;
    end
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_reg <= GEN_RESET;
    else
      st_reg <= st_next;
  end

  assign io.rise = st_reg.rise;
  assign io.fall = st_reg.fall;

  //////////////////////////////////////////////////////////////////////////////////////////////

  gen_period_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ3
    (st_reg.rise && st_reg.seen && io.input_select && $stable(io.divider))
    |-> st_reg.cyc == ((12'(io.divider) + 12'h001) << 2))
    else $error("Bit clock period differs from one plus divider input periods.");

  gen_high_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ4
    (st_reg.fall && st_reg.seen && io.input_select && $stable(io.divider))
    |-> st_reg.cyc == (12'(ssp_pkg::hi_halves(io.divider)) << 1))
    else $error("Bit clock high width is wrong for this divider.");

  gen_source_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ2
    (st_reg.rise && !io.input_select && !$past(io.input_select))
    |-> $past(io.ext_level, 1) != $past(io.ext_level, 2))
    else $error("External input selected but edge came without an external edge.");

endmodule

// ==== hdl/ssp_gen_if.sv ====
// Link between the port logic and its bit-clock generator.
`timescale 1ns/1ps
interface ssp_gen_if;
  logic       run;           // Generator runs while high, else parks at the start of high.
  logic       input_select;  // One selects CPU clock over four, zero the external clock.
  logic [7:0] divider;       // Divider field of the generator.
  logic       ext_level;     // Synchronised external sample-rate clock.
  logic       rise;          // One-cycle pulse at each generated rising edge.
  logic       fall;          // One-cycle pulse at each generated falling edge.

  modport gen  (input run, input input_select, input divider, input ext_level,
                output rise, output fall);
  modport user (output run, output input_select, output divider, output ext_level,
                input rise, input fall);
endinterface

// ==== hdl/ssp_pkg.sv ====
// Shared constants, state type and phase-width functions for the SPI clock-stop serial port.
package ssp_pkg;

  // Bits in one serial word, shifted most significant bit first.
  localparam int WORD_BITS = 8;

  // Bit-clock rise number that carries the last bit of a word.
  localparam logic [3:0] LAST_BIT = 4'h8;

  // Bit-clock rise number at which a master frame closes.
  localparam logic [3:0] END_RISE = 4'h9;

  // Clock-stop mode encodings; the upper bit set means clock-stop operation.
  localparam logic [1:0] MODE_EARLY = 2'b10;
  localparam logic [1:0] MODE_LATE  = 2'b11;

  // Generator setting forced in the slave role: CPU-derived input, divider one.
  localparam logic       SLAVE_SEL = 1'b1;
  localparam logic [7:0] SLAVE_DIV = 8'h01;

  // System clock cycles per generator input period when the CPU input is selected.
  localparam int CPU_PER_INPUT = 4;

  // Positions of the inputs inside the synchroniser vectors.
  localparam int SY_DR   = 0;
  localparam int SY_RXFS = 1;
  localparam int SY_TXFS = 2;
  localparam int SY_RXC  = 3;
  localparam int SY_TXC  = 4;
  localparam int SY_EXT  = 5;

  // Port state; Gray code along idle to master, while idle to slave changes both bits.
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE  = 2'b11
  } ssp_state_t;

  // High phase width in half input periods; zero and odd dividers split evenly.
  function automatic logic [8:0] hi_halves(input logic [7:0] div);
    hi_halves = (!div[0] && div != 8'h00) ? {1'b0, div} + 9'h002 : {1'b0, div} + 9'h001;
  endfunction

  // Low phase width in half input periods.
  function automatic logic [8:0] lo_halves(input logic [7:0] div);
    lo_halves = (!div[0] && div != 8'h00) ? {1'b0, div} : {1'b0, div} + 9'h001;
  endfunction

endpackage

// ==== hdl/ssp_top.sv ====
// SPI clock-stop serial port, master or slave, with its bit-clock generator.
`timescale 1ns/1ps
// What this block does
// [RQ1] Slave role forces generator to CPU over four.
// [RQ2] Input select picks CPU over four or pin.
// [RQ3] Bit clock period is divider plus one inputs.
// [RQ4] Even nonzero divider: high one longer; else even split.
// [RQ5] Master drives frame sync inverted as slave select.
// [RQ6] Slave inverts active-low select inputs before use.
// [RQ7] Master: transmit clock, sync out; receive in.
// [RQ8] Slave: all clocks and frame syncs inputs.
// [RQ9] Select low before rising edge starts transfer.
// [RQ10] Receive data sampled on rising bit clock.
// [RQ11] Transmit data changes after falling bit clock.
// [RQ12] Master select leads first edge by set time.
// [RQ13] Master select trails last edge by set time.
// [RQ14] Slave releases data pin when select rises.
// [RQ15] Slave drives first bit when select falls.
// [RQ16] Master clock idles at polarity between words.
module ssp_top
(
  input  wire logic       sys_clk,            // 25 MHz system clock, also the CPU clock.
  input  wire logic       rst,                // Synchronous reset, active high.
  input  wire logic       role_master,        // One for master, zero for slave.
  input  wire logic [1:0] clock_stop_mode,    // Clock-stop mode, 10b or 11b.
  input  wire logic       tx_clock_polarity,  // Idle level of the bit clock pin.
  input  wire logic       tx_sync_polarity,   // One: transmit frame sync is active low.
  input  wire logic       rx_sync_polarity,   // One: receive frame sync is active low.
  input  wire logic       gen_input_select,   // Generator input select, master role.
  input  wire logic [7:0] gen_divider,        // Generator divider, master role.
  input  wire logic       ext_sample_clock,   // External sample-rate clock pin.
  input  wire logic [7:0] tx_word,            // Word to send.
  input  wire logic       tx_start,           // Master: start a word while idle.
  input  wire logic       tx_bit_clock_i,     // Transmit bit clock pin level.
  input  wire logic       rx_bit_clock_i,     // Receive bit clock pin level.
  input  wire logic       tx_frame_sync_i,    // Transmit frame sync pin level.
  input  wire logic       rx_frame_sync_i,    // Receive frame sync pin level.
  input  wire logic       rx_data_pin,        // Receive data pin.
  output logic            tx_bit_clock_o,     // Transmit bit clock drive value.
  output logic            tx_bit_clock_oe,    // Transmit bit clock driven.
  output logic            tx_frame_sync_o,    // Transmit frame sync drive value.
  output logic            tx_frame_sync_oe,   // Transmit frame sync driven.
  output logic            tx_data_o,          // Transmit data drive value.
  output logic            tx_data_oe,         // Transmit data driven.
  output logic [7:0]      rx_word,            // Last word received.
  output logic            rx_valid,           // Pulse: rx_word was just updated.
  output logic            busy,               // Master frame in progress.
  output logic            tx_clock_dir,       // Transmit clock direction, one is output.
  output logic            tx_sync_dir,        // Transmit sync direction, one is output.
  output logic            rx_clock_dir,       // Receive clock direction, one is output.
  output logic            rx_sync_dir         // Receive sync direction, one is output.
);

  // Whole state of the port.
  typedef struct packed
  {
    logic [5:0]          sy1;      // First synchroniser stage, read only by the second.
    logic [5:0]          sy2;      // Second synchroniser stage.
    logic [5:0]          prev;     // Second stage one cycle late, for edges.
    ssp_pkg::ssp_state_t state;    // Port state.
    logic                run;      // Generator run request.
    logic                gen_sel;  // Effective generator input select.
    logic [7:0]          gen_div;  // Effective generator divider.
    logic [3:0]          rcnt;     // Master: rising edges since the frame began; slave: set to one at the first rise after select.
    logic [3:0]          rbits;    // Slave bits received in the current word.
    logic [7:0]          tx_sh;    // Transmit shifter.
    logic [7:0]          rx_sh;    // Receive shifter.
    logic [7:0]          rx_word;  // Received word.
    logic                rx_valid; // Word-received pulse.
    logic                busy;     // Master frame in progress.
    logic                clk_int;  // Internal bit clock, before pin inversion.
    logic                clk_pin;  // Bit clock pin value.
    logic                fs_pin;   // Frame sync pin value.
    logic                data_o;   // Data pin value.
    logic                data_oe;  // Data pin driven.
    logic                txc_dir;  // Direction flags.
    logic                txs_dir;
    logic                rxc_dir;
    logic                rxs_dir;
  } ssp_top_state_t;

  localparam ssp_top_state_t TOP_RESET = '0;
  localparam int             MSB       = ssp_pkg::WORD_BITS - 1;

  ssp_top_state_t st_reg;
  ssp_top_state_t st_next;
  logic           early;      // Mode 10b: first clock edge is a fall.
  logic           inv;        // Pin clock is the internal clock inverted.
  logic           sel_tx;     // Internal transmit select, active high.
  logic           sel_tx_p;
  logic           sel_rx;     // Internal receive select, active high.
  logic           tx_rise;
  logic           tx_fall;
  logic           rx_rise;
  logic [3:0]     r1;         // Master rise count after this rise.

  ssp_gen_if gen_bus();

  //////////////////////////////////////////////////////////////////////////////////////////////

  // Generator driven from registered settings, so a mid-word change lands cleanly.
  assign gen_bus.run          = st_reg.run;
  assign gen_bus.input_select = st_reg.gen_sel;
  assign gen_bus.divider      = st_reg.gen_div;
  assign gen_bus.ext_level    = st_reg.sy2[ssp_pkg::SY_EXT];

  ssp_clkgen u_gen
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .io      (gen_bus)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////

  // Next-state logic for both roles. Every edge pulse is taken from the second stage on.
  always_comb
  begin
    st_next          = st_reg;
    st_next.rx_valid = 1'b0;
    st_next.sy1      = {ext_sample_clock, tx_bit_clock_i, rx_bit_clock_i,
                        tx_frame_sync_i, rx_frame_sync_i, rx_data_pin};
    st_next.sy2      = st_reg.sy1;
    st_next.prev     = st_reg.sy2;
    early    = clock_stop_mode == ssp_pkg::MODE_EARLY;
    inv      = tx_clock_polarity ^ early;
    // Slave select is inverted before use when its sync polarity bit marks it active low.
    sel_tx   = st_reg.sy2[ssp_pkg::SY_TXFS] ^ tx_sync_polarity;   // RQ6
    sel_tx_p = st_reg.prev[ssp_pkg::SY_TXFS] ^ tx_sync_polarity;
    sel_rx   = st_reg.sy2[ssp_pkg::SY_RXFS] ^ rx_sync_polarity;   // RQ6
    tx_rise  = (st_reg.sy2[ssp_pkg::SY_TXC] ^ inv) & ~(st_reg.prev[ssp_pkg::SY_TXC] ^ inv);
    tx_fall  = ~(st_reg.sy2[ssp_pkg::SY_TXC] ^ inv) & (st_reg.prev[ssp_pkg::SY_TXC] ^ inv);
    rx_rise  = (st_reg.sy2[ssp_pkg::SY_RXC] ^ inv) & ~(st_reg.prev[ssp_pkg::SY_RXC] ^ inv);
    r1       = st_reg.rcnt + 4'h1;
    // Only the transmit pair can ever drive; the receive pair is input in both roles.
    st_next.txc_dir = role_master;  // RQ7 RQ8
    st_next.txs_dir = role_master;  // RQ7 RQ8
    st_next.rxc_dir = 1'b0;         // RQ7 RQ8
    st_next.rxs_dir = 1'b0;         // RQ7 RQ8
    st_next.gen_sel = role_master ? gen_input_select : ssp_pkg::SLAVE_SEL;  // RQ1
    st_next.gen_div = role_master ? gen_divider : ssp_pkg::SLAVE_DIV;       // RQ1
    case (st_reg.state)
      ssp_pkg::ST_IDLE:
      begin
        // Between words the clock rests at its polarity level.
        st_next.run     = 1'b0;
        st_next.busy    = 1'b0;
        st_next.clk_int = early;  // RQ16
        st_next.data_oe = 1'b0;
        st_next.fs_pin  = tx_sync_polarity;
        if (!role_master)
        begin
          st_next.state = ssp_pkg::ST_SLAVE;
        end
        else if (tx_start && clock_stop_mode[1])
        begin
          // Select goes active now; the generator's start counts as rise zero.
          st_next.state   = ssp_pkg::ST_MASTER;
          st_next.run     = 1'b1;
          st_next.busy    = 1'b1;
          st_next.fs_pin  = ~tx_sync_polarity;  // RQ5 RQ9 RQ12
          st_next.data_oe = 1'b1;
          st_next.data_o  = tx_word[MSB];
          st_next.tx_sh   = tx_word;
          st_next.rcnt    = 4'h0;
        end
      end
      ssp_pkg::ST_MASTER:
      begin
        if (gen_bus.rise)
        begin
          st_next.rcnt = r1;
          if (r1 == ssp_pkg::END_RISE)
          begin
            // A period after the last rise is a low width after the last fall too.
            st_next.state   = ssp_pkg::ST_IDLE;  // RQ13
            st_next.run     = 1'b0;
            st_next.busy    = 1'b0;
            st_next.fs_pin  = tx_sync_polarity;
            st_next.data_oe = 1'b0;
            st_next.clk_int = early;  // RQ16
          end
          else
          begin
            // Rise zero is hidden, so the first visible rise is a period after select.
            st_next.clk_int = 1'b1;  // RQ12
            st_next.rx_sh   = {st_reg.rx_sh[MSB-1:0], st_reg.sy2[ssp_pkg::SY_DR]};  // RQ10
            if (r1 == ssp_pkg::LAST_BIT)
            begin
              st_next.rx_word  = {st_reg.rx_sh[MSB-1:0], st_reg.sy2[ssp_pkg::SY_DR]};
              st_next.rx_valid = 1'b1;
            end
          end
        end
        else if (gen_bus.fall)
        begin
          // Mode 10b shows the fall before rise one; mode 11b shows the one after rise eight.
          if (early ? st_reg.rcnt < ssp_pkg::LAST_BIT
                    : (st_reg.rcnt != 4'h0 && st_reg.rcnt <= ssp_pkg::LAST_BIT))
          begin
            st_next.clk_int = 1'b0;  // RQ12 RQ13
          end
          if (st_reg.rcnt != 4'h0 && st_reg.rcnt < ssp_pkg::LAST_BIT)
          begin
            st_next.tx_sh  = st_reg.tx_sh << 1;
            st_next.data_o = st_reg.tx_sh[MSB-1];  // RQ11
          end
        end
      end
      ssp_pkg::ST_SLAVE:
      begin
        st_next.run  = 1'b0;
        st_next.busy = 1'b0;
        if (role_master)
        begin
          st_next.state   = ssp_pkg::ST_IDLE;
          st_next.data_oe = 1'b0;
        end
        else
        begin
          if (sel_tx && !sel_tx_p)
          begin
            // First bit goes out on select alone, before any clock edge.
            st_next.data_oe = 1'b1;  // RQ15
            st_next.data_o  = tx_word[MSB];
            st_next.tx_sh   = tx_word;
            st_next.rcnt    = 4'h0;
          end
          else if (!sel_tx)
          begin
            st_next.data_oe = 1'b0;  // RQ14
          end
          else
          begin
            if (tx_rise)
              st_next.rcnt = 4'h1;
            // A fall before the first rise (mode 10b) must not skip bit one.
            if (tx_fall && st_reg.rcnt != 4'h0)
            begin
              st_next.tx_sh  = st_reg.tx_sh << 1;
              st_next.data_o = st_reg.tx_sh[MSB-1];  // RQ11
            end
          end
          if (!sel_rx)
          begin
            st_next.rbits = 4'h0;
          end
          else if (rx_rise)
          begin
            st_next.rx_sh = {st_reg.rx_sh[MSB-1:0], st_reg.sy2[ssp_pkg::SY_DR]};  // RQ10
            if (st_reg.rbits + 4'h1 == ssp_pkg::LAST_BIT)
            begin
              st_next.rx_word  = {st_reg.rx_sh[MSB-1:0], st_reg.sy2[ssp_pkg::SY_DR]};
              st_next.rx_valid = 1'b1;
              st_next.rbits    = 4'h0;
            end
            else
            begin
              st_next.rbits = st_reg.rbits + 4'h1;
            end
          end
        end
      end
      default:
      begin
        st_next.state = ssp_pkg::ST_IDLE;
      end
    endcase
    st_next.clk_pin = st_next.clk_int ^ inv;
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_reg <= TOP_RESET;
    else
      st_reg <= st_next;
  end

  assign tx_bit_clock_o   = st_reg.clk_pin;
  assign tx_bit_clock_oe  = st_reg.txc_dir;
  assign tx_frame_sync_o  = st_reg.fs_pin;
  assign tx_frame_sync_oe = st_reg.txs_dir;
  assign tx_data_o        = st_reg.data_o;
  assign tx_data_oe       = st_reg.data_oe;
  assign rx_word          = st_reg.rx_word;
  assign rx_valid         = st_reg.rx_valid;
  assign busy             = st_reg.busy;
  assign tx_clock_dir     = st_reg.txc_dir;
  assign tx_sync_dir      = st_reg.txs_dir;
  assign rx_clock_dir     = st_reg.rxc_dir;
  assign rx_sync_dir      = st_reg.rxs_dir;

  //////////////////////////////////////////////////////////////////////////////////////////////

  // The edge that leaves reset still shows reset settings, so it cannot start a check.
  slave_gen_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ1
    !rst && !role_master ##1 !role_master
    |-> gen_bus.input_select == ssp_pkg::SLAVE_SEL && gen_bus.divider == ssp_pkg::SLAVE_DIV)
    else $error("Slave role did not force the generator to CPU over four.");

  master_dirs_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ7
    busy |-> tx_clock_dir && tx_sync_dir && !rx_clock_dir && !rx_sync_dir)
    else $error("Master frame with wrong pin directions.");

  slave_dirs_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ8
    !role_master ##1 !role_master |-> !tx_bit_clock_oe && !tx_frame_sync_oe
                                      && !rx_clock_dir && !rx_sync_dir)
    else $error("Slave role drives a clock or frame sync pin.");

  master_select_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ5
    busy && $stable(tx_sync_polarity) |-> tx_frame_sync_o == !tx_sync_polarity)
    else $error("Slave select not active during a master frame.");

  idle_clock_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ16
    role_master && !busy && !$past(busy) && $stable(tx_clock_polarity)
    && $stable(clock_stop_mode) |-> tx_bit_clock_o == tx_clock_polarity)
    else $error("Master bit clock moved between words.");

  frame_end_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ13
    $fell(busy) |-> $past(gen_bus.rise) && $past(st_reg.rcnt) == ssp_pkg::LAST_BIT)
    else $error("Master select released at the wrong edge.");

  slave_release_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ14
    st_reg.state == ssp_pkg::ST_SLAVE && !role_master && !sel_tx |=> !tx_data_oe)
    else $error("Slave still drives data after select went inactive.");

  slave_first_a: assert property (@(posedge sys_clk) disable iff (rst)  // RQ15
    st_reg.state == ssp_pkg::ST_SLAVE && !role_master && sel_tx && !sel_tx_p
    |=> tx_data_oe && tx_data_o == $past(tx_word[MSB]))
    else $error("Slave did not present the first bit on select.");

endmodule

// ==== tb/ssp_peer.sv ====
// Wire-level model of the far SPI peer.
`timescale 1ns/1ps
module ssp_peer
(
  input  wire logic       clk_pin,  // Bit clock on the wire.
  input  wire logic       sel_n,    // Active-low select on the wire.
  input  wire logic       mosi,     // Data from the port.
  input  wire logic [7:0] reply,    // Word sent back.
  output logic            miso,     // Data to the port.
  output logic [7:0]      seen      // Word taken from the port.
);
  logic [7:0] shift_reg;  // Bits still to send.
  logic       rose_reg;   // A rise came in this frame.
  initial {miso, seen, shift_reg, rose_reg} = 18'h0_0000;
  // Select low shows the first bit before any clock edge.
  always @(negedge sel_n)
  begin
    shift_reg = reply;
    rose_reg = 1'b0;
    miso = reply[7];
  end
  // Released, the line shows the inverse so a stale bit never passes.
  always @(posedge sel_n)
    miso = ~miso;
  // Port data is taken on the rise.
  always @(posedge clk_pin)
    if (!sel_n)
    begin
      seen = {seen[6:0], mosi};
      rose_reg = 1'b1;
    end
  // Shift after a fall, but not the lead-in fall.
  always @(negedge clk_pin)
    if (!sel_n && rose_reg)
    begin
      shift_reg = shift_reg << 1;
      miso = shift_reg[7];
    end
endmodule

// ==== tb/test_ssp_top.sv ====
// Self-checking bench for the SPI clock-stop port.
`timescale 1ns/1ps
module test_ssp_top;
  logic       sys_clk = 0, rst = 1, role = 0, pol = 0, start = 0, sclk = 1, sel_n = 1;
  logic [1:0] mode = 2'b11;
  logic [7:0] div = 8'h01, word = 8'h00, reply = 8'h00;
  logic       gsel = 1, ext = 0;
  int         errors = 0, compares = 0, ph = 0, got = 0;
  wire        tclk, tclk_oe, tfs, tfs_oe, tdat, tdat_oe, rxv, busy, tcd, tsd, rcd, rsd, miso;
  wire [7:0]  rxw, seen;
  always #20 sys_clk = ~sys_clk;
  // External sample-rate clock: one level change every third cycle, a six-cycle period.
  always @(posedge sys_clk)
  begin
    ph <= ph == 2 ? 0 : ph + 1;
    if (ph == 2)
      ext <= ~ext;
  end
  // Counts rx_valid pulses; each received word must give exactly one.
  always @(negedge sys_clk)
    if (rxv === 1'b1)
      got++;
  ssp_top dut_u (.sys_clk(sys_clk), .rst(rst), .role_master(role), .clock_stop_mode(mode),
    .tx_clock_polarity(pol), .tx_sync_polarity(1'b1), .rx_sync_polarity(1'b1),
    .gen_input_select(gsel), .gen_divider(div), .ext_sample_clock(ext), .tx_word(word),
    .tx_start(start), .tx_bit_clock_i(sclk), .rx_bit_clock_i(sclk), .tx_frame_sync_i(sel_n),
    .rx_frame_sync_i(sel_n), .rx_data_pin(miso), .tx_bit_clock_o(tclk),
    .tx_bit_clock_oe(tclk_oe), .tx_frame_sync_o(tfs), .tx_frame_sync_oe(tfs_oe),
    .tx_data_o(tdat), .tx_data_oe(tdat_oe), .rx_word(rxw), .rx_valid(rxv), .busy(busy),
    .tx_clock_dir(tcd), .tx_sync_dir(tsd), .rx_clock_dir(rcd), .rx_sync_dir(rsd));
  // The peer sees the port's own pins as master, the bench's pins as slave; its clock is
  // the internal one, so it samples on the internal rise in every mode and polarity.
  ssp_peer peer_u (.clk_pin((role ? tclk : sclk) ^ pol ^ (mode == 2'b10)),
    .sel_n(role ? tfs : sel_n),
    .mosi(tdat_oe ? tdat : ~tdat), .reply(reply), .miso(miso), .seen(seen));
  task chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task summarize;
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One master word; measures select lead and the first active phase. hp is cycles per
  // half input period: 2 for the CPU input, 3 for the external clock, whose phase is free.
  task master(input logic [1:0] m, input logic p, input logic [7:0] d, w, r, input int hp);
    int n, n1, k, e;
    k = hp * ((!d[0] && d != 0) ? d + 2 : d + 1);  // High width in cycles.
    e = m[0] ? 2 * hp * (d + 1) : k;               // Select lead in cycles.
    @(posedge sys_clk);
    {role, mode, pol, div, word, reply} <= {1'b1, m, p, d, w, r};
    gsel <= hp == 2;
    got = 0;
    repeat (3) @(negedge sys_clk);
    chk({tcd, tsd, tclk_oe, tfs_oe, rcd, rsd} === 6'h3c, "master dirs");
    @(posedge sys_clk);
    start <= 1;
    @(posedge sys_clk);
    start <= 0;
    for (n = 0; tfs !== 0 && n < 50; n++) @(negedge sys_clk);
    for (n = 0; tclk === p && n < 500; n++) @(negedge sys_clk);
    for (n1 = 0; tclk !== p && n1 < 500; n1++) @(negedge sys_clk);
    chk(n >= e && n - e < (hp == 2 ? 1 : hp), "select lead");
    chk(n1 === (m[0] ? k : 2 * hp * (d + 1) - k), "phase width");
    for (n = 0; busy !== 0 && n < 900; n++) @(negedge sys_clk);
    chk(seen === w && rxw === r && got === 1 && tclk === p, "master word");
    repeat (20) @(negedge sys_clk);
    chk(tclk === p && tfs === 1 && tdat_oe === 0, "idle gap");
  endtask
  // One slave word in mode 10b, polarity one, half period 8 cycles.
  task slave(input logic [7:0] w, r);
    @(posedge sys_clk);
    {role, mode, pol, word, reply} <= {1'b0, 2'b10, 1'b1, w, r};
    got = 0;
    repeat (3) @(negedge sys_clk);
    chk({tcd, tsd, tclk_oe, tfs_oe, rcd, rsd} === 6'h00, "slave dirs");
    @(posedge sys_clk);
    sel_n <= 0;  // Select leads the first clock edge.
    repeat (6) @(negedge sys_clk);
    chk(tdat_oe === 1 && tdat === w[7], "slave first bit");
    repeat (16)
    begin
      repeat (8) @(posedge sys_clk);
      sclk <= ~sclk;
    end
    repeat (8) @(negedge sys_clk);
    chk(rxw === r && seen === w && got === 1, "slave word");
    @(posedge sys_clk);
    sel_n <= 1;
    repeat (8) @(negedge sys_clk);
    chk(tdat_oe === 0, "slave release");
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    master(2'b11, 1'b0, 8'h02, 8'ha5, 8'h5a, 2);
    master(2'b10, 1'b1, 8'h03, 8'h3c, 8'hc3, 2);
    master(2'b11, 1'b0, 8'h01, 8'h81, 8'h7e, 2);
    master(2'b11, 1'b1, 8'h01, 8'h42, 8'h24, 3);
    slave(8'h96, 8'h69);
    summarize;
  end
  // A hang ends the run as a failure.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    summarize;
  end
endmodule
